// ==== rtl/cfs_pkg.sv ====
`default_nettype none

package cfs_pkg;

  // register width and command codes on the management bus
  localparam int CFS_REG_W = 8;
  localparam logic [7:0] CFS_CMD_BUS_LIMIT = 8'hD7;
  localparam logic [7:0] CFS_CMD_SERIOUS = 8'hD8;

  // reset values and the answer to an unmapped read
  localparam logic [7:0] CFS_RESET_BYTE = 8'h00;
  localparam logic [7:0] CFS_IDLE_BYTE = 8'h00;

  // bus_voltage_limit_faults field positions
  localparam int CFS_LV_OUT_OV = 0;
  localparam int CFS_LV_OUT_UV = 1;
  localparam int CFS_LV_IN_OV = 2;
  localparam int CFS_LV_IN_UV = 3;
  localparam int CFS_HV_OUT_OV = 4;
  localparam int CFS_HV_OUT_UV = 5;
  localparam int CFS_HV_IN_OV = 6;
  localparam int CFS_HV_IN_UV = 7;

  // bits that count only in buck mode; the rest only in boost mode
  localparam logic [7:0] CFS_BUCK_QUAL_MASK = 8'h43;

  // serious_short_faults field positions
  localparam int CFS_SER_HS_SHORT = 0;
  localparam int CFS_SER_LV_GND = 1;
  localparam int CFS_SER_LS_SHORT = 2;
  localparam int CFS_SER_HV_GND = 3;
  localparam int CFS_SER_FLY_SHORT = 4;
  localparam int CFS_SER_USED = 5;
  localparam logic [7:0] CFS_SER_IMPL_MASK = 8'h1F;

endpackage : cfs_pkg

`default_nettype wire

// ==== rtl/cfs_flag_bit.sv ====
`timescale 1ns/10ps
`default_nettype none

module cfs_flag_bit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // detector level from the analog side, not yet synchronised
  input wire logic i_raw,
  // mode qualifier, already on this clock
  input wire logic i_qual,
  // host clear pulse for this bit
  input wire logic i_clear,
  // sticky flag
  output logic o_flag
);

  logic sync_a;
  logic sync_b;
  logic set_now;

  // set only when the synchronised detector agrees with the mode
  assign set_now = sync_b & i_qual;

  // two-stage synchroniser; sync_a feeds sync_b and nothing else
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_raw;
      sync_b <= sync_a;
    end
  end

  // sticky flag: a set in the clearing cycle wins so no event is lost
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= set_now | (o_flag & ~i_clear);
    end
  end

endmodule // cfs_flag_bit

`default_nettype wire

// ==== rtl/cfs_fault_status.sv ====
`timescale 1ns/10ps
`default_nettype none

module cfs_fault_status
  import cfs_pkg::*;
(
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // conversion direction, high in buck mode
  input wire logic I_BUCK_MODE,
  // protection-level comparators
  input wire logic I_LV_OUT_OV,
  input wire logic I_LV_OUT_UV,
  input wire logic I_LV_IN_OV,
  input wire logic I_LV_IN_UV,
  input wire logic I_HV_OUT_OV,
  input wire logic I_HV_OUT_UV,
  input wire logic I_HV_IN_OV,
  input wire logic I_HV_IN_UV,
  // serious fault detectors
  input wire logic I_HS_SHORT,
  input wire logic I_LV_GND_SHORT,
  input wire logic I_LS_SHORT,
  input wire logic I_HV_GND_SHORT,
  input wire logic I_FLY_SHORT,
  // management bus command port
  input wire logic [7:0] I_REG_CMD,
  input wire logic I_REG_WR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic I_REG_RD,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_ACK,
  // live register contents
  output logic [7:0] O_BUS_LIMIT_FAULTS,
  output logic [7:0] O_SERIOUS_FAULTS
);

  logic mode_a;
  logic buck_mode;
  logic [7:0] bus_raw;
  logic [4:0] ser_raw;
  logic [7:0] bus_qual;
  logic [7:0] bus_flags;
  logic [4:0] ser_flags;
  logic hit_bus;
  logic hit_ser;
  logic [7:0] bus_clear;
  logic [4:0] ser_clear;
  logic [7:0] next_rdata;
  logic next_ack;

  // mode sync matches the detector sync depth so qualifier and event line up
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      mode_a <= 1'b0;
      buck_mode <= 1'b0;
    end else begin
      mode_a <= I_BUCK_MODE;
      buck_mode <= mode_a;
    end
  end

  // detector bundles in register bit order
  assign bus_raw = {I_HV_IN_UV, I_HV_IN_OV, I_HV_OUT_UV, I_HV_OUT_OV,
                    I_LV_IN_UV, I_LV_IN_OV, I_LV_OUT_UV, I_LV_OUT_OV};
  assign ser_raw = {I_FLY_SHORT, I_HV_GND_SHORT, I_LS_SHORT, I_LV_GND_SHORT, I_HS_SHORT};

  // each bus-limit bit counts only in its own conversion direction
  assign bus_qual = (CFS_BUCK_QUAL_MASK & {CFS_REG_W{buck_mode}}) |
                    (~CFS_BUCK_QUAL_MASK & {CFS_REG_W{~buck_mode}});

  // command decode; writing a one clears that flag, zeros leave it alone
  assign hit_bus = (I_REG_CMD == CFS_CMD_BUS_LIMIT);
  assign hit_ser = (I_REG_CMD == CFS_CMD_SERIOUS);
  assign bus_clear = I_REG_WDATA & {CFS_REG_W{I_REG_WR & hit_bus}};
  assign ser_clear = I_REG_WDATA[CFS_SER_USED-1:0] & {CFS_SER_USED{I_REG_WR & hit_ser}};

  // bus-limit flags, one sticky bit each
  for (genvar i = 0; i < CFS_REG_W; i++) begin : g_bus
    cfs_flag_bit u_flag (
      .i_clk(I_CORE_CLK),
      .i_reset(I_RESET),
      .i_raw(bus_raw[i]),
      .i_qual(bus_qual[i]),
      .i_clear(bus_clear[i]),
      .o_flag(bus_flags[i])
    );
  end

  // serious flags are not mode qualified: a short is a short either way
  for (genvar j = 0; j < CFS_SER_USED; j++) begin : g_ser
    cfs_flag_bit u_flag (
      .i_clk(I_CORE_CLK),
      .i_reset(I_RESET),
      .i_raw(ser_raw[j]),
      .i_qual(1'b1),
      .i_clear(ser_clear[j]),
      .o_flag(ser_flags[j])
    );
  end

  // live views; reserved serious bits are held at zero
  assign O_BUS_LIMIT_FAULTS = bus_flags;
  assign O_SERIOUS_FAULTS = {{(CFS_REG_W-CFS_SER_USED){1'b0}}, ser_flags};

  // read mux; an unmapped code reads as zero and gets no acknowledge
  assign next_rdata = !I_REG_RD ? CFS_IDLE_BYTE :
                      hit_bus ? O_BUS_LIMIT_FAULTS :
                      hit_ser ? O_SERIOUS_FAULTS : CFS_IDLE_BYTE;
  assign next_ack = (I_REG_RD | I_REG_WR) & (hit_bus | hit_ser);

  // registered answer, one cycle after the request
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_REG_RDATA <= CFS_RESET_BYTE;
      O_REG_ACK <= 1'b0;
    end else begin
      O_REG_RDATA <= next_rdata;
      O_REG_ACK <= next_ack;
    end
  end

  // checks: detector to flag takes three samples (two sync, one latch)
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  sequence buck_event_s(logic sig);
    sig && I_BUCK_MODE;
  endsequence

  sequence boost_event_s(logic sig);
    sig && !I_BUCK_MODE;
  endsequence

  // host writes that clear one bit of either register
  sequence bus_clear_s(int pos);
    I_REG_WR && hit_bus && I_REG_WDATA[pos];
  endsequence

  sequence ser_clear_s(int pos);
    I_REG_WR && hit_ser && I_REG_WDATA[pos];
  endsequence

  lv_out_ov_a: assert property (buck_event_s(I_LV_OUT_OV) |->
    ##3 O_BUS_LIMIT_FAULTS[CFS_LV_OUT_OV])
    else $error("low bus output overvoltage flag not set");
  lv_ov_cause_a: assert property ($rose(O_BUS_LIMIT_FAULTS[CFS_LV_OUT_OV]) |->
    $past(I_LV_OUT_OV, 3) && $past(I_BUCK_MODE, 3))
    else $error("low bus output overvoltage flag set without cause");
  lv_out_uv_a: assert property ($rose(O_BUS_LIMIT_FAULTS[CFS_LV_OUT_UV]) |->
    $past(I_LV_OUT_UV, 3) && $past(I_BUCK_MODE, 3))
    else $error("low bus output undervoltage flag set without cause");
  lv_in_ov_a: assert property (boost_event_s(I_LV_IN_OV) |->
    ##3 O_BUS_LIMIT_FAULTS[CFS_LV_IN_OV])
    else $error("low bus input overvoltage flag not set");
  lv_in_uv_a: assert property ($rose(O_BUS_LIMIT_FAULTS[CFS_LV_IN_UV]) |->
    $past(I_LV_IN_UV, 3) && !$past(I_BUCK_MODE, 3))
    else $error("low bus input undervoltage flag set without cause");
  hv_out_ov_a: assert property (boost_event_s(I_HV_OUT_OV) |->
    ##3 O_BUS_LIMIT_FAULTS[CFS_HV_OUT_OV])
    else $error("high bus output overvoltage flag not set");
  hv_out_uv_a: assert property (boost_event_s(I_HV_OUT_UV) |->
    ##3 O_BUS_LIMIT_FAULTS[CFS_HV_OUT_UV])
    else $error("high bus output undervoltage flag not set");
  hv_in_ov_a: assert property ($rose(O_BUS_LIMIT_FAULTS[CFS_HV_IN_OV]) |->
    $past(I_HV_IN_OV, 3) && $past(I_BUCK_MODE, 3))
    else $error("high bus input overvoltage flag set without cause");
  hv_in_uv_a: assert property (boost_event_s(I_HV_IN_UV) |->
    ##3 O_BUS_LIMIT_FAULTS[CFS_HV_IN_UV])
    else $error("high bus input undervoltage flag not set");
  bus_read_a: assert property (I_REG_RD && hit_bus |=>
    O_REG_ACK && O_REG_RDATA == $past(O_BUS_LIMIT_FAULTS))
    else $error("bus-limit read returned wrong data");
  ser_read_a: assert property (I_REG_RD && hit_ser |=>
    O_REG_ACK && O_REG_RDATA == $past(O_SERIOUS_FAULTS))
    else $error("serious-fault read returned wrong data");
  reset_zero_a: assert property (disable iff (1'b0) I_RESET |=>
    O_BUS_LIMIT_FAULTS == CFS_RESET_BYTE && O_SERIOUS_FAULTS == CFS_RESET_BYTE)
    else $error("fault registers not zero after reset");
  hs_short_a: assert property (I_HS_SHORT |-> ##3 O_SERIOUS_FAULTS[CFS_SER_HS_SHORT])
    else $error("high-side short flag not set");
  ls_short_a: assert property (I_LS_SHORT |->
    ##3 O_SERIOUS_FAULTS[CFS_SER_LS_SHORT])
    else $error("low-side short flag not set");
  hv_gnd_a: assert property (I_HV_GND_SHORT |->
    ##3 O_SERIOUS_FAULTS[CFS_SER_HV_GND])
    else $error("high bus ground short flag not set");
  fly_short_a: assert property (I_FLY_SHORT |->
    ##3 O_SERIOUS_FAULTS[CFS_SER_FLY_SHORT])
    else $error("flyback switch short flag not set");
  reserved_zero_a: assert property ((O_SERIOUS_FAULTS & ~CFS_SER_IMPL_MASK) == CFS_RESET_BYTE)
    else $error("reserved serious bits not zero");
  lv_gnd_a: assert property (I_LV_GND_SHORT |->
    ##3 O_SERIOUS_FAULTS[CFS_SER_LV_GND])
    else $error("low bus ground short flag not set");
  sticky_hold_a: assert property (O_BUS_LIMIT_FAULTS[CFS_LV_OUT_OV] &&
    !(I_REG_WR && hit_bus && I_REG_WDATA[CFS_LV_OUT_OV]) |=> O_BUS_LIMIT_FAULTS[CFS_LV_OUT_OV])
    else $error("latched flag dropped without a clear");
  clear_works_a: assert property (!I_HS_SHORT ##2 ser_clear_s(CFS_SER_HS_SHORT)
    |=> !O_SERIOUS_FAULTS[CFS_SER_HS_SHORT])
    else $error("host clear did not clear the flag");
  bus_clear_a: assert property (!I_LV_OUT_OV ##2 bus_clear_s(CFS_LV_OUT_OV)
    |=> !O_BUS_LIMIT_FAULTS[CFS_LV_OUT_OV])
    else $error("host clear did not clear the bus-limit flag");
  set_wins_a: assert property (I_LS_SHORT ##2 ser_clear_s(CFS_SER_LS_SHORT)
    |=> O_SERIOUS_FAULTS[CFS_SER_LS_SHORT])
    else $error("event in the clearing cycle was lost");
  ack_map_a: assert property ((I_REG_RD || I_REG_WR) && (hit_bus || hit_ser)
    |=> O_REG_ACK)
    else $error("mapped request not acknowledged");
  unmapped_a: assert property ((I_REG_RD || I_REG_WR) && !hit_bus && !hit_ser
    |=> !O_REG_ACK && O_REG_RDATA == CFS_IDLE_BYTE)
    else $error("unmapped request answered");
  rdata_idle_a: assert property (!I_REG_RD |=> O_REG_RDATA == CFS_IDLE_BYTE)
    else $error("read data did not fall back to idle");

endmodule // cfs_fault_status

`default_nettype wire

// ==== testbench/cfs_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module cfs_host_model (
  // clock
  input wire logic i_clk,
  // command port toward the device
  output logic [7:0] o_cmd,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_rd,
  // answer from the device
  input wire logic [7:0] i_rdata,
  input wire logic i_ack
);
  // idle bus at time zero
  initial begin
    o_cmd = 8'h00;
    o_wr = 1'b0;
    o_wdata = 8'h00;
    o_rd = 1'b0;
  end

  // one byte transfer; strobe stands for one edge, the answer is read in the cycle after
  task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [7:0] wdata,
    output logic [7:0] rdata, output logic ack);
    @(posedge i_clk);
    #1;
    o_cmd = cmd;
    o_wr = wr;
    o_rd = !wr;
    o_wdata = wdata;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    // released fields show no stale values
    o_cmd = ~cmd;
    o_wdata = ~wdata;
    rdata = i_rdata;
    ack = i_ack;
  endtask
endmodule // cfs_host_model

`default_nettype wire

// ==== testbench/cfs_fault_status_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module cfs_fault_status_test;
  import cfs_pkg::*;
  logic clk, rst, buck, wr, rd, ack, ack_v;
  logic [7:0] lim, cmd, wdata, rdata, lim_q, ser_q, rd_v;
  logic [4:0] ser;
  int num_errors;
  int n_checks;

  cfs_fault_status i_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_BUCK_MODE(buck),
    .I_LV_OUT_OV(lim[0]), .I_LV_OUT_UV(lim[1]), .I_LV_IN_OV(lim[2]), .I_LV_IN_UV(lim[3]),
    .I_HV_OUT_OV(lim[4]), .I_HV_OUT_UV(lim[5]), .I_HV_IN_OV(lim[6]), .I_HV_IN_UV(lim[7]),
    .I_HS_SHORT(ser[0]), .I_LV_GND_SHORT(ser[1]), .I_LS_SHORT(ser[2]),
    .I_HV_GND_SHORT(ser[3]), .I_FLY_SHORT(ser[4]), .I_REG_CMD(cmd), .I_REG_WR(wr),
    .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
    .O_BUS_LIMIT_FAULTS(lim_q), .O_SERIOUS_FAULTS(ser_q));

  cfs_host_model i_host (.i_clk(clk), .o_cmd(cmd), .o_wr(wr), .o_wdata(wdata), .o_rd(rd),
    .i_rdata(rdata), .i_ack(ack));

  // 20 MHz core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp, input logic exp_ack);
    i_host.xfer(c, 1'b0, 8'h00, rd_v, ack_v);
    chk(rd_v, exp);
    chk({7'h00, ack_v}, {7'h00, exp_ack});
  endtask

  task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
    i_host.xfer(c, 1'b1, d, rd_v, ack_v);
    chk({7'h00, ack_v}, 8'h01);
  endtask

  // one-cycle detector pulse, then wait until the flag has had time to land;
  // whole bundles are driven because a bit passed as inout only lands on return
  task automatic pulse(input logic [7:0] lim_bits, input logic [4:0] ser_bits);
    @(posedge clk);
    #1;
    lim = lim_bits;
    ser = ser_bits;
    @(posedge clk);
    #1;
    lim = 8'h00;
    ser = 5'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk(lim_q, CFS_RESET_BYTE);
    chk(ser_q, CFS_RESET_BYTE);
    rd_chk(CFS_CMD_BUS_LIMIT, 8'h00, 1'b1);
    rd_chk(CFS_CMD_SERIOUS, 8'h00, 1'b1);
  endtask

  // each limit bit in both directions; the wrong direction must leave it clear
  task automatic t_limits;
    logic [7:0] exp;
    for (int m = 0; m < 2; m++) begin
      buck = m[0];
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        pulse(8'h01 << i, 5'h00);
        exp = (CFS_BUCK_QUAL_MASK[i] == m[0]) ? (8'h01 << i) : 8'h00;
        chk(lim_q, exp);
        rd_chk(CFS_CMD_BUS_LIMIT, exp, 1'b1);
        wr_reg(CFS_CMD_BUS_LIMIT, 8'hFF);
        chk(lim_q, 8'h00);
      end
    end
  endtask

  // serious flags: latch, ignore zeros and reserved bits, clear by a one
  task automatic t_serious;
    for (int i = 0; i < 5; i++) begin
      pulse(8'h00, 5'h01 << i);
      chk(ser_q, 8'h01 << i);
      wr_reg(CFS_CMD_SERIOUS, 8'hE0);
      rd_chk(CFS_CMD_SERIOUS, 8'h01 << i, 1'b1);
      wr_reg(CFS_CMD_SERIOUS, 8'h01 << i);
      chk(ser_q, 8'h00);
    end
  endtask

  // unmapped code gets no answer and changes nothing; read data falls back after one cycle
  task automatic t_unmapped;
    pulse(8'h00, 5'h01);
    rd_chk(8'hD9, 8'h00, 1'b0);
    i_host.xfer(8'hD9, 1'b1, 8'hFF, rd_v, ack_v);
    chk({7'h00, ack_v}, 8'h00);
    rd_chk(CFS_CMD_BUS_LIMIT, 8'h00, 1'b1);
    rd_chk(CFS_CMD_SERIOUS, 8'h01, 1'b1);
    @(posedge clk);
    #1;
    chk(rdata, CFS_IDLE_BYTE);
    chk({7'h00, ack}, 8'h00);
    wr_reg(CFS_CMD_SERIOUS, 8'h01);
    chk(ser_q, 8'h00);
  endtask

  // a detector event landing in the clearing cycle keeps the flag set
  task automatic t_setwins;
    @(posedge clk);
    #1;
    ser = 5'h04;
    @(posedge clk);
    #1;
    ser = 5'h00;
    wr_reg(CFS_CMD_SERIOUS, 8'h04);
    chk(ser_q, 8'h04);
    wr_reg(CFS_CMD_SERIOUS, 8'h04);
    chk(ser_q, 8'h00);
  endtask

  // reset in mid-run drops latched flags; the host may ask right after release
  task automatic t_midreset;
    pulse(8'h01, 5'h10);
    chk(lim_q, 8'h01);
    chk(ser_q, 8'h10);
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(lim_q, CFS_RESET_BYTE);
    chk(ser_q, CFS_RESET_BYTE);
    rd_chk(CFS_CMD_SERIOUS, CFS_RESET_BYTE, 1'b1);
    rd_chk(CFS_CMD_BUS_LIMIT, CFS_RESET_BYTE, 1'b1);
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    buck = 1'b0;
    lim = 8'h00;
    ser = 5'h00;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_limits();
    t_serious();
    t_unmapped();
    t_setwins();
    t_midreset();
    test_done();
  end
endmodule // cfs_fault_status_test

`default_nettype wire
